// file: core/i2c_status_seq.sv
// I2C master transfer sequencer with status flags and APB registers
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module i2c_status_seq
    import i2c_seq_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n
);
    // ==========================================================
    // Register bus decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    logic [7:0] mode_reg;
    logic [7:0] tgt_reg;
    logic [7:0] irq_en;
    logic [7:0] sticky;

    wire acc      = psel & penable & pready;
    wire setup    = psel & ~penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire wr_mode  = wr & hit(paddr, ADDR_MODE);
    wire wr_tgt   = wr & hit(paddr, ADDR_TARGET);
    wire wr_stat  = wr & hit(paddr, ADDR_STATUS);
    wire wr_tx    = wr & hit(paddr, ADDR_TXBUF);
    wire wr_clr   = wr & hit(paddr, ADDR_IRQ_CLEAR);
    wire wr_en    = wr & hit(paddr, ADDR_IRQ_ENABLE);
    wire rd_rx    = rd & hit(paddr, ADDR_RXBUF);
    wire mapped   = hit(paddr, ADDR_MODE) | hit(paddr, ADDR_TARGET)
                  | hit(paddr, ADDR_STATUS) | hit(paddr, ADDR_TXBUF)
                  | hit(paddr, ADDR_RXBUF) | hit(paddr, ADDR_IRQ_STATUS)
                  | hit(paddr, ADDR_IRQ_CLEAR) | hit(paddr, ADDR_IRQ_ENABLE);

    // ==========================================================
    // Sequencer state
    seq_state_e state;
    logic [1:0] ph;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] cur_tgt;
    logic [4:0] rxcnt;
    logic       is_addr;
    logic       pend_rs;
    logic       nack_seen;
    logic       tick;

    wire       tx_valid;
    wire [7:0] tx_data;
    wire [2:0] tx_count;
    wire       tx_ready;
    wire [7:0] rx_data;
    wire [2:0] rx_count;

    wire       busy      = (state != ST_IDLE);
    wire       launch    = wr_tgt & mode_reg[MODE_EN_BIT];
    wire       is_read   = cur_tgt[DIR_BIT];
    wire       receiving = is_read & ~is_addr;
    wire       last      = (rxcnt == mode_reg[RCOUNT_HI:0]);
    wire       ack_end   = tick & (state == ST_ACK) & (ph == 2'h3);
    wire       abort     = ack_end & ~receiving & nack_seen;
    wire       more      = receiving ? ~last : (is_addr ? (is_read | tx_valid) : tx_valid);
    wire       cont      = ~abort & more & ~pend_rs;
    wire       tx_pop    = ack_end & cont & ~is_read;
    wire       rx_push   = ack_end & receiving;

    // Leftover TX bytes are useless after an abort, so drop them
    byte_fifo u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .flush     (abort),
        .in_valid  (wr_tx),
        .in_ready  (tx_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data),
        .count     (tx_count)
    );

    // Pushes into a full RX FIFO are dropped; software must keep up
    byte_fifo u_rx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .flush     (1'b0),
        .in_valid  (rx_push),
        .in_ready  (),
        .in_data   (shreg),
        .out_valid (),
        .out_ready (rd_rx),
        .out_data  (rx_data),
        .count     (rx_count)
    );

    quarter_tick u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .rate    (mode_reg[RATE_HI:RATE_LO]),
        .tick    (tick)
    );

    // ==========================================================
    // Status flags
    function automatic logic [1:0] level_of(input logic [2:0] cnt);
        return (cnt == 3'h0) ? LVL_EMPTY : (cnt == FIFO_FULL_CNT) ? LVL_FULL : LVL_HALF;
    endfunction : level_of

    wire [1:0] level = level_of(is_read ? rx_count : tx_count);
    wire [7:0] sticky_set;
    wire [7:0] sticky_clr;
    wire [7:0] next_sticky;
    wire [7:0] status_rd;

    assign sticky_set[BUSY_BIT]   = 1'b0;
    assign sticky_set[NACK_BIT]   = abort;
    assign sticky_set[RXIRQ_BIT]  = (rx_count != 3'h0);
    assign sticky_set[TXIRQ_BIT]  = (tx_count == 3'h0);
    assign sticky_set[LEVEL_HI:LEVEL_LO] = 2'h0;
    assign sticky_set[ACCERR_BIT] = busy & ((wr_tx & is_read) | (rd_rx & ~is_read));
    assign sticky_set[OVFERR_BIT] = wr_tx & ~tx_ready;
    assign sticky_clr = ({8{wr_stat}} & ~pwdata[7:0]) | ({8{wr_clr}} & pwdata[7:0]);
    // Hardware set wins over a clear in the same cycle
    assign next_sticky = (sticky_set | (sticky & ~sticky_clr)) & STICKY_MASK;
    assign status_rd = {busy, sticky[6:4], level, sticky[1:0]};

    wire [7:0] rd_mux = hit(paddr, ADDR_MODE)       ? mode_reg  :
                        hit(paddr, ADDR_TARGET)     ? tgt_reg   :
                        hit(paddr, ADDR_STATUS)     ? status_rd :
                        hit(paddr, ADDR_RXBUF)      ? rx_data   :
                        hit(paddr, ADDR_IRQ_STATUS) ? sticky    :
                        hit(paddr, ADDR_IRQ_ENABLE) ? irq_en    : 8'h00;

    // ==========================================================
    // Registers and bus answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_reg <= MODE_RESET;
            tgt_reg  <= TARGET_RESET;
            irq_en   <= 8'h00;
            sticky   <= 8'h00;
            irq      <= 1'b0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
        end else begin
            if (wr_mode)
                mode_reg <= pwdata[7:0];
            if (wr_tgt)
                tgt_reg <= pwdata[7:0];
            if (wr_en)
                irq_en <= pwdata[7:0] & STICKY_MASK;
            sticky  <= next_sticky;
            irq     <= |(next_sticky & irq_en);
            // pready registered from setup lets prdata come from a flop with no wait state
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup)
                prdata <= {24'h0, rd_mux};
        end
    end

    // ==========================================================
    // Bit and byte sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            ph        <= 2'h0;
            bitcnt    <= 3'h0;
            shreg     <= 8'h00;
            cur_tgt   <= 8'h00;
            rxcnt     <= 5'h00;
            is_addr   <= 1'b0;
            pend_rs   <= 1'b0;
            nack_seen <= 1'b0;
            scl_oe_n  <= 1'b1;
            sda_oe_n  <= 1'b1;
            scl_o     <= 1'b0;
            sda_o     <= 1'b0;
        end else if (launch && !busy) begin
            state   <= ST_START;
            ph      <= 2'h0;
            cur_tgt <= pwdata[7:0];
        end else begin
            if (launch)
                pend_rs <= 1'b1;
            if (tick && busy) begin
                ph <= ph + 2'h1;
                unique case (state)
                    ST_START, ST_RSTART: begin
                        unique case (ph)
                            2'h0: sda_oe_n <= 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b0;
                            2'h3: begin
                                scl_oe_n <= 1'b0;
                                state    <= ST_BYTE;
                                shreg    <= cur_tgt;
                                bitcnt   <= 3'h7;
                                is_addr  <= 1'b1;
                                rxcnt    <= 5'h00;
                            end
                        endcase
                    end
                    ST_BYTE: begin
                        unique case (ph)
                            2'h0: sda_oe_n <= receiving | shreg[7];
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: if (receiving) shreg <= {shreg[6:0], sda_i};
                            2'h3: begin
                                scl_oe_n <= 1'b0;
                                if (!receiving)
                                    shreg <= {shreg[6:0], 1'b0};
                                if (bitcnt == 3'h0)
                                    state <= ST_ACK;
                                bitcnt <= bitcnt - 3'h1;
                            end
                        endcase
                    end
                    ST_ACK: begin
                        unique case (ph)
                            // Master ack on reads, NACK on the last byte
                            2'h0: sda_oe_n <= ~receiving | last;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: nack_seen <= sda_i;
                            2'h3: begin
                                scl_oe_n <= 1'b0;
                                bitcnt   <= 3'h7;
                                if (abort) begin
                                    state <= ST_STOP;
                                end else if (cont) begin
                                    state   <= ST_BYTE;
                                    is_addr <= 1'b0;
                                    if (receiving)
                                        rxcnt <= rxcnt + 5'h01;
                                    if (tx_pop)
                                        shreg <= tx_data;
                                end else if (pend_rs) begin
                                    state   <= ST_RSTART;
                                    cur_tgt <= tgt_reg;
                                    pend_rs <= 1'b0;
                                end else begin
                                    state <= ST_STOP;
                                end
                            end
                        endcase
                    end
                    ST_STOP: begin
                        unique case (ph)
                            2'h0: sda_oe_n <= 1'b0;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b1;
                            2'h3: begin
                                state   <= pend_rs ? ST_START : ST_IDLE;
                                cur_tgt <= pend_rs ? tgt_reg : cur_tgt;
                                pend_rs <= 1'b0;
                            end
                        endcase
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    property p_flush_on_abort;
        @(posedge clk_sys) disable iff (!rst_n) abort |=> tx_count == 3'h0;
    endproperty
    a_flush_on_abort: assert property (p_flush_on_abort)
        else $error("TX FIFO not emptied after abort");

    property p_nack_flag;
        @(posedge clk_sys) disable iff (!rst_n) abort |=> sticky[NACK_BIT];
    endproperty
    a_nack_flag: assert property (p_nack_flag)
        else $error("Missing ack flag not set");

    property p_abort_stop;
        @(posedge clk_sys) disable iff (!rst_n)
            abort |=> (state == ST_STOP) && (ph == 2'h0);
    endproperty
    a_abort_stop: assert property (p_abort_stop)
        else $error("Transfer not stopped after missing ack");

    property p_rx_irq;
        @(posedge clk_sys) disable iff (!rst_n) rx_count != 3'h0 |=> sticky[RXIRQ_BIT];
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("RX interrupt flag missing");

    property p_tx_irq;
        @(posedge clk_sys) disable iff (!rst_n) tx_count == 3'h0 |=> sticky[TXIRQ_BIT];
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("TX interrupt flag missing");

    property p_sticky_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            sticky[NACK_BIT] && !sticky_clr[NACK_BIT] |=> sticky[NACK_BIT];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("Sticky flag lost without a clear");

    property p_level_full;
        @(posedge clk_sys) disable iff (!rst_n)
            !is_read && tx_count == FIFO_FULL_CNT |-> status_rd[3:2] == LVL_FULL;
    endproperty
    a_level_full: assert property (p_level_full)
        else $error("Level field not full");

    property p_overflow;
        @(posedge clk_sys) disable iff (!rst_n)
            wr_tx && tx_count == FIFO_FULL_CNT && !tx_pop && !abort
            |=> sticky[OVFERR_BIT] && tx_count == FIFO_FULL_CNT;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("Overflow flag not set");

    property p_last_nack;
        @(posedge clk_sys) disable iff (!rst_n)
            tick && state == ST_ACK && ph == 2'h0 && receiving && last |=> sda_oe_n;
    endproperty
    a_last_nack: assert property (p_last_nack)
        else $error("Final byte not NACKed");

    property p_launch;
        @(posedge clk_sys) disable iff (!rst_n)
            launch && !busy |=> state == ST_START ##1 busy;
    endproperty
    a_launch: assert property (p_launch)
        else $error("Address write did not launch");

    property p_tick_space;
        @(posedge clk_sys) disable iff (!rst_n) tick |=> !tick [*3];
    endproperty
    a_tick_space: assert property (p_tick_space)
        else $error("Quarter tick too fast");

    c_abort:   cover property (@(posedge clk_sys) disable iff (!rst_n) abort);
    c_restart: cover property (@(posedge clk_sys) disable iff (!rst_n) state == ST_RSTART);
    c_rx_done: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_push && last);
endmodule : i2c_status_seq

// file: core/i2c_seq_pkg.sv
// Shared constants and types of the I2C master status sequencer
package i2c_seq_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_MODE       = 8'h00;
    localparam logic [7:0] ADDR_TARGET     = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_TXBUF      = 8'h0c;
    localparam logic [7:0] ADDR_RXBUF      = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;

    // ==========================================================
    // Field positions
    localparam int MODE_EN_BIT    = 7;
    localparam int RATE_HI        = 6;
    localparam int RATE_LO        = 5;
    localparam int RCOUNT_HI      = 4;
    localparam int DIR_BIT        = 0;
    localparam int BUSY_BIT       = 7;
    localparam int NACK_BIT       = 6;
    localparam int RXIRQ_BIT      = 5;
    localparam int TXIRQ_BIT      = 4;
    localparam int LEVEL_HI       = 3;
    localparam int LEVEL_LO       = 2;
    localparam int ACCERR_BIT     = 1;
    localparam int OVFERR_BIT     = 0;

    // ==========================================================
    // Reset values and encodings
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [7:0] STICKY_MASK  = 8'h73;
    localparam logic [1:0] LVL_EMPTY    = 2'h0;
    localparam logic [1:0] LVL_HALF     = 2'h2;
    localparam logic [1:0] LVL_FULL     = 2'h3;

    // ==========================================================
    // Sizes and counts
    localparam int         FIFO_DEPTH   = 4;
    localparam int         FIFO_AW      = 2;
    localparam logic [2:0] FIFO_FULL_CNT = 3'h4;
    // Core cycles per quarter SCL period at rate 0 (16 per bit / 4)
    localparam logic [6:0] QUARTER_BASE = 7'h04;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_START  = 6'h02,
        ST_BYTE   = 6'h04,
        ST_ACK    = 6'h08,
        ST_STOP   = 6'h10,
        ST_RSTART = 6'h20
    } seq_state_e;

endpackage : i2c_seq_pkg

// file: core/byte_fifo.sv
// Four-entry byte FIFO with flush and fill count
`timescale 1ns/100ps
module byte_fifo
    import i2c_seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       flush,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [7:0]      out_data,
    output logic [2:0]      count
);
    logic [7:0]         mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    wire                push = in_valid & in_ready;
    wire                pop  = out_valid & out_ready;

    assign in_ready  = (count != FIFO_FULL_CNT);
    assign out_valid = (count != 3'h0);
    assign out_data  = mem[rp];

    always_ff @(posedge clk_sys) begin
        if (push)
            mem[wp] <= in_data;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || flush) begin
            wp    <= '0;
            rp    <= '0;
            count <= 3'h0;
        end else begin
            if (push)
                wp <= wp + 2'h1;
            if (pop)
                rp <= rp + 2'h1;
            count <= count + {2'h0, push} - {2'h0, pop};
        end
    end
endmodule : byte_fifo

// file: core/quarter_tick.sv
// Quarter-bit enable pulse for the serial clock
`timescale 1ns/100ps
module quarter_tick
    import i2c_seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [1:0] rate,
    output logic            tick
);
    logic [6:0] cnt;
    wire  [6:0] limit = (QUARTER_BASE << rate) - 7'h01;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else begin
            tick <= (cnt >= limit);
            cnt  <= (cnt >= limit) ? 7'h00 : cnt + 7'h01;
        end
    end
endmodule : quarter_tick

// file: dv/i2c_slave_model.sv
// Behavioural I2C slave that answers the sequencer on the wired bus
`timescale 1ns/100ps
module i2c_slave_model #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic refuse,
    output logic      sda_oe_n,
    output logic [7:0] got,
    output int        macks
);
    // ==========================================================
    // Bit tracking, driven only while scl is low
    logic [3:0] bit_n;
    logic [7:0] sh;
    logic [7:0] dat;
    logic       act;
    logic       adr;
    logic       rd;
    logic       ok;
    initial begin
        sda_oe_n = 1'b1;
        act = 1'b0;
        macks = 0;
        got = 8'h00;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        adr = 1'b1;
        // Start edge is followed by an scl fall that must land on bit 0
        bit_n = 4'hf;
        sda_oe_n = 1'b1;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) if (act) begin
        if (bit_n < 4'h8) sh = {sh[6:0], sda};
        else if (rd && !adr && ok) begin
            // Master NACK ends our driving so that its stop can happen
            ok = !sda;
            if (!sda) macks++;
        end
    end
    always @(negedge scl) if (act) begin
        if (bit_n == 4'h8) begin
            bit_n = 4'h0;
            if (!adr && rd) dat = dat + 8'h11;
            adr = 1'b0;
        end else bit_n = bit_n + 4'h1;
        sda_oe_n = 1'b1;
        if (bit_n == 4'h8 && adr) begin
            rd = sh[0];
            ok = (sh[7:1] == SLAVE_ADDR) && !refuse;
            dat = 8'h5a;
            sda_oe_n = !ok;
        end else if (bit_n == 4'h8 && !rd) begin
            if (ok) got = sh;
            sda_oe_n = !ok;
        end else if (bit_n < 4'h8 && rd && !adr && ok) sda_oe_n = dat[3'h7 - bit_n[2:0]];
    end
endmodule : i2c_slave_model

// file: dv/i2c_master_status_sequencer_tb.sv
// Self-checking bench of the I2C status sequencer
`timescale 1ns/100ps
module i2c_master_status_sequencer_tb import i2c_seq_pkg::*;;
    // ==========================================================
    // Signals
    localparam logic [6:0] SADR = 7'h2a;
    logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, refuse = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, scl_o, scl_oe_n, sda_o, sda_oe_n, s_oe_n, err;
    wire logic   scl = scl_oe_n;
    wire logic   sda = sda_oe_n & s_oe_n;
    logic [7:0]  got, q;
    logic [7:0]  wv [4] = '{8'h22, 8'h33, 8'h44, 8'h55};
    logic [7:0]  rv [3] = '{8'h5a, 8'h6b, 8'h7c};
    int          macks, per, n_start = 0, n_stop = 0, n_mismatch = 0, total_checks = 0;
    realtime     t0, t1;
    always #2 clk_sys = ~clk_sys;
    i2c_status_seq u_dut (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .irq, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda),
        .sda_o, .sda_oe_n);
    i2c_slave_model #(.SLAVE_ADDR(SADR)) u_slave (.scl, .sda, .refuse, .sda_oe_n(s_oe_n),
        .got, .macks);
    always @(negedge sda) if (scl === 1'b1) n_start++;
    always @(posedge sda) if (scl === 1'b1) n_stop++;
    always @(posedge scl) begin
        t0 = t1;
        t1 = $realtime;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        paddr  <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        psel   <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Answer is taken at the very edge that samples pready high
        do @(posedge clk_sys); while (pready !== 1'b1);
        q   = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle();
        do apb(ADDR_STATUS, 1'b0, 8'h00); while (q[BUSY_BIT] === 1'b1);
    endtask : wait_idle
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        n_start = 0;
        n_stop = 0;
        apb(ADDR_STATUS, 1'b0, 8'h00);
        chk("status_rst", q, 8'h10);
        apb(8'h20, 1'b0, 8'h00);
        chk("unmapped_err", {7'h0, err}, 8'h01);
        chk("unmapped_data", q, 8'h00);
        apb(ADDR_MODE, 1'b1, 8'ha0);
        apb(ADDR_TXBUF, 1'b1, 8'h11);
        apb(ADDR_STATUS, 1'b1, 8'hef);
        apb(ADDR_STATUS, 1'b0, 8'h00);
        chk("txirq_clr_half", q, 8'h08);
        foreach (wv[i]) apb(ADDR_TXBUF, 1'b1, wv[i]);
        apb(ADDR_STATUS, 1'b0, 8'h00);
        chk("full_ovf", q, 8'h0d);
        apb(ADDR_TARGET, 1'b1, {SADR, 1'b0});
        apb(ADDR_STATUS, 1'b0, 8'h00);
        chk("busy", q & 8'h80, 8'h80);
        wait_idle();
        chk("wr_last", got, 8'h44);
        chk("wr_done", q, 8'h11);
        per = int'((t1 - t0) / 4.0);
        chk("scl_period", per[7:0], 8'h20);
        // Read of three bytes with a stray transmit write while busy
        apb(ADDR_MODE, 1'b1, 8'h82);
        apb(ADDR_TARGET, 1'b1, {SADR, 1'b1});
        apb(ADDR_TXBUF, 1'b1, 8'h66);
        wait_idle();
        chk("rd_status", q & 8'h2e, 8'h2a);
        foreach (rv[i]) begin
            apb(ADDR_RXBUF, 1'b0, 8'h00);
            chk("rx_data", q, rv[i]);
        end
        chk("master_acks", macks[7:0], 8'h02);
        apb(ADDR_STATUS, 1'b0, 8'h00);
        chk("rx_drained", q & 8'h0c, 8'h00);
        // Address refused by the slave
        refuse <= 1'b1;
        apb(ADDR_IRQ_ENABLE, 1'b1, 8'h40);
        apb(ADDR_STATUS, 1'b1, 8'h00);
        apb(ADDR_TXBUF, 1'b1, 8'h77);
        apb(ADDR_TARGET, 1'b1, {SADR, 1'b0});
        wait_idle();
        chk("nack_flush", q & 8'h4c, 8'h40);
        chk("no_data", got, 8'h44);
        chk("irq_on", {7'h0, irq}, 8'h01);
        apb(ADDR_IRQ_ENABLE, 1'b1, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk("irq_mask", {7'h0, irq}, 8'h00);
        apb(ADDR_IRQ_CLEAR, 1'b1, 8'h40);
        apb(ADDR_IRQ_STATUS, 1'b0, 8'h00);
        chk("irq_clr", q & 8'h40, 8'h00);
        // Target rewritten while the write is running
        refuse <= 1'b0;
        apb(ADDR_MODE, 1'b1, 8'h81);
        apb(ADDR_TXBUF, 1'b1, 8'h88);
        apb(ADDR_TARGET, 1'b1, {SADR, 1'b0});
        apb(ADDR_TARGET, 1'b1, {SADR, 1'b1});
        wait_idle();
        apb(ADDR_RXBUF, 1'b0, 8'h00);
        chk("rs_rx", q, 8'h5a);
        chk("starts", n_start[7:0], 8'h05);
        chk("stops", n_stop[7:0], 8'h04);
        give_verdict();
    end
endmodule : i2c_master_status_sequencer_tb
